// >>> rtl/sgp_gp_stream.sv
// General-purpose serial stream initiator with APB register access
//
// Functional notes
// - Receive config count field is read-only remaining repetitions; FFh means endless.
// - Count sets how many marker, shift-out and capture passes run.
// - Count FFh repeats streams until software writes another count.
// - Each stream starts with the four pattern bits on frame sync, bit 0 first.
// - Receive words hold every bit captured since the latest frame marker.
// - First receive word: bit 1 at byte 3 bit 0, bit 32 at byte 0 bit 7.
// - Second receive word: bit 33 at byte 3 bit 0, bit 64 at byte 0 bit 7.
// - Transmit words shift out on serial out from bit 0, alongside the frame marker.
// - First transmit word: byte 3 bit 0 first, byte 0 bit 7 as bit 32.
// - Second transmit word: byte 3 bit 0 as bit 33, byte 0 bit 7 as 64.
// - Receive group: config index 00h, first word 01h, second word 02h.
// - Transmit group: config index 00h, first word 01h, second word 02h.
// - Each of four links owns three consecutive bits, link 0 bits 0 to 2.
// - Without known SATA support the stream ends after bit 11.
// - With SATA known on any link the stream carries 192 bits.
// - Port-multiplier positions follow in three-bit groups up to bit 191.
// - Unfilled multiplier positions are still sent, tristated; target ignores them.
// - Several initiators may share one serial clock and frame sync line; here frame_sync_line has no enable and is always driven.
//
// The APB register port was decided locally.
`default_nettype none
module sgp_gp_stream (
	// Clock, reset, enable
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 clk_en,
	// APB slave
	input  wire sgp_pkg::sgp_apb_req_t apb_req,
	output var  sgp_pkg::sgp_apb_rsp_t apb_rsp,
	// Serial link
	input  wire logic                 serial_clock_line,
	input  wire logic                 serial_in_line,
	output logic                      frame_sync_line,
	output logic                      serial_out_line,
	output logic                      serial_out_oe
);
	import sgp_pkg::*;

	sgp_regs_t  q;
	sgp_regs_t  d;
	logic       agree_ck;
	logic       rise;
	logic       fall;
	logic       present;
	logic [7:0] pidx;
	logic [7:0] last_idx;
	logic       last_bit;
	logic       acc;
	logic       done;
	logic       wr_cfg;
	logic       mapped;
	logic       fs_expect;
	logic       do_expect;

	// Serial clock edges from the filtered level
	assign agree_ck = q.ck_sy[1] == q.ck_sy[2];
	assign rise     = agree_ck && q.ck_sy[2] && !q.ck_lv;
	assign fall     = agree_ck && !q.ck_sy[2] && q.ck_lv;

	// Stream bookkeeping
	assign present  = fall && (q.st == SGP_RUN || q.cnt != SGP_CNT_RST);
	assign pidx     = (q.st == SGP_IDLE) ? 8'h00 : q.idx;
	assign last_idx = q.sata ? SGP_LAST_LONG : SGP_LAST_SHORT;
	assign last_bit = q.idx >= last_idx;

	// Expected pin values for the bit being presented
	assign fs_expect = (pidx < SGP_MARK_BITS) ? q.pat[pidx[1:0]] : 1'b0;
	assign do_expect = (pidx < SGP_DATA_BITS) ?
		(pidx[5] ? q.tx2[sgp_pos(pidx[4:0])] : q.tx1[sgp_pos(pidx[4:0])]) : 1'b0;

	// APB phases
	assign acc    = apb_req.psel && apb_req.penable;
	assign done   = acc && q.rsp.pready;
	assign wr_cfg = done && apb_req.pwrite && !q.rsp.pslverr && apb_req.paddr == SGP_TX_CFG;

	always_comb begin
		unique case (apb_req.paddr)
			SGP_TX_CFG, SGP_TX_W1, SGP_TX_W2, SGP_RX_CFG, SGP_RX_W1, SGP_RX_W2,
			SGP_CTRL_ADDR: mapped = 1'b1;
			default:       mapped = 1'b0;
		endcase
	end

	always_comb begin
		d = q;
		// Three-stage synchronisers, level follows once stages two and three agree
		d.ck_sy = {q.ck_sy[1:0], serial_clock_line};
		d.di_sy = {q.di_sy[1:0], serial_in_line};
		if (agree_ck) begin
			d.ck_lv = q.ck_sy[2];
		end
		if (q.di_sy[1] == q.di_sy[2]) begin
			d.di_lv = q.di_sy[2];
		end

		// Falling edge: present the next bit or go quiet
		if (fall) begin
			if (present) begin
				d.st   = SGP_RUN;
				d.idx  = pidx;
				d.fs   = fs_expect;
				d.dout = do_expect;
				d.doe  = pidx < SGP_DATA_BITS;
				if (q.st == SGP_IDLE) begin
					d.rx1 = SGP_WORD_RST;
					d.rx2 = SGP_WORD_RST;
				end
			end else begin
				d.fs   = 1'b0;
				d.dout = 1'b0;
				d.doe  = 1'b0;
			end
		end

		// Rising edge: capture inbound bit, advance or end the stream
		if (rise && q.st == SGP_RUN) begin
			if (q.idx < SGP_DATA_BITS) begin
				if (q.idx[5]) begin
					d.rx2[sgp_pos(q.idx[4:0])] = q.di_lv;
				end else begin
					d.rx1[sgp_pos(q.idx[4:0])] = q.di_lv;
				end
			end
			if (last_bit) begin
				d.st = SGP_IDLE;
				if (q.cnt != SGP_CNT_INF && q.cnt != SGP_CNT_RST) begin
					d.cnt = q.cnt - 8'h01;
				end
			end else begin
				d.idx = q.idx + 8'h01;
			end
		end

		// APB: one wait state, answer and error both registered
		if (acc && !q.rsp.pready) begin
			d.rsp.pready  = 1'b1;
			d.rsp.pslverr = !mapped;
			d.rsp.prdata  = SGP_WORD_RST;
			if (!apb_req.pwrite) begin
				unique case (apb_req.paddr)
					SGP_TX_CFG: d.rsp.prdata = (32'(q.pat) << SGP_PAT_LSB) |
						(32'(q.cnt) << SGP_CNT_LSB);
					SGP_RX_CFG: d.rsp.prdata = 32'(q.cnt) << SGP_CNT_LSB;
					SGP_TX_W1:  d.rsp.prdata = q.tx1;
					SGP_TX_W2:  d.rsp.prdata = q.tx2;
					SGP_RX_W1:  d.rsp.prdata = q.rx1;
					SGP_RX_W2:  d.rsp.prdata = q.rx2;
					SGP_CTRL_ADDR: d.rsp.prdata = 32'(q.sata) << SGP_SATA_BIT;
					default:    d.rsp.prdata = SGP_WORD_RST;
				endcase
			end
		end else begin
			d.rsp.pready  = 1'b0;
			d.rsp.pslverr = 1'b0;
		end

		// Writes take effect at the completing edge and win over the stream update
		if (done && apb_req.pwrite && !q.rsp.pslverr) begin
			unique case (apb_req.paddr)
				SGP_TX_CFG: begin
					d.cnt = apb_req.pwdata[SGP_CNT_LSB +: 8];
					d.pat = apb_req.pwdata[SGP_PAT_LSB +: 4];
				end
				SGP_TX_W1:     d.tx1  = apb_req.pwdata;
				SGP_TX_W2:     d.tx2  = apb_req.pwdata;
				SGP_CTRL_ADDR: d.sata = apb_req.pwdata[SGP_SATA_BIT];
				default:       d.sata = q.sata;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q      <= '0;
			q.st   <= SGP_IDLE;
			q.cnt  <= SGP_CNT_RST;
			q.pat  <= SGP_PAT_RST;
			q.sata <= SGP_SATA_RST;
			q.tx1  <= SGP_WORD_RST;
			q.tx2  <= SGP_WORD_RST;
			q.rx1  <= SGP_WORD_RST;
			q.rx2  <= SGP_WORD_RST;
		end else if (clk_en) begin
			q <= d;
		end
	end

	assign apb_rsp         = q.rsp;
	assign frame_sync_line = q.fs;
	assign serial_out_line = q.dout;
	assign serial_out_oe   = q.doe;

	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_present;
		clk_en && present;
	endsequence

	sequence s_end;
		clk_en && rise && q.st == SGP_RUN && last_bit;
	endsequence

	sequence s_capture;
		clk_en && rise && q.st == SGP_RUN;
	endsequence

	sequence s_ask;
		clk_en && acc && !q.rsp.pready;
	endsequence

	property p_marker;
		s_present ##0 (pidx < SGP_MARK_BITS) |=> frame_sync_line == $past(q.pat[pidx[1:0]]);
	endproperty
	a_marker: assert property (p_marker) else $error("frame marker bit wrong");

	property p_tx_map;
		s_present ##0 (pidx == 8'h00) |=> serial_out_line == $past(q.tx1[24]);
	endproperty
	a_tx_map: assert property (p_tx_map) else $error("first outbound bit wrong");

	property p_tristate;
		s_present ##0 (pidx >= SGP_DATA_BITS) |=> !serial_out_oe;
	endproperty
	a_tristate: assert property (p_tristate) else $error("multiplier bit driven");

	property p_len_short;
		q.st == SGP_RUN && !q.sata |-> q.idx <= SGP_LAST_SHORT;
	endproperty
	a_len_short: assert property (p_len_short) else $error("short stream overran");

	property p_len_end;
		s_end |=> q.st == SGP_IDLE;
	endproperty
	a_len_end: assert property (p_len_end) else $error("stream did not end");

	property p_dec;
		s_end ##0 (q.cnt != SGP_CNT_INF && q.cnt != SGP_CNT_RST && !wr_cfg)
			|=> q.cnt == $past(q.cnt) - 8'h01;
	endproperty
	a_dec: assert property (p_dec) else $error("count not decremented");

	property p_inf;
		q.cnt == SGP_CNT_INF && !wr_cfg |=> q.cnt == SGP_CNT_INF;
	endproperty
	a_inf: assert property (p_inf) else $error("endless count changed");

	property p_idle;
		q.st == SGP_IDLE && q.cnt == SGP_CNT_RST && !wr_cfg |=> q.st == SGP_IDLE;
	endproperty
	a_idle: assert property (p_idle) else $error("stream started with zero count");

	property p_rx_first;
		clk_en && rise && q.st == SGP_RUN && q.idx == 8'h00 |=> q.rx1[24] == $past(q.di_lv);
	endproperty
	a_rx_first: assert property (p_rx_first) else $error("first inbound bit misplaced");

	property p_rx_clear;
		s_present ##0 (q.st == SGP_IDLE) |=> q.rx1 == SGP_WORD_RST && q.rx2 == SGP_WORD_RST;
	endproperty
	a_rx_clear: assert property (p_rx_clear) else $error("receive words not cleared");

	property p_rsv;
		clk_en && acc && !q.rsp.pready && !apb_req.pwrite && apb_req.paddr == SGP_RX_CFG
			|=> apb_rsp.pready && apb_rsp.prdata[15:0] == 16'h0000 && apb_rsp.prdata[31:24] == 8'h00;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");

	property p_marker_off;
		s_present ##0 (pidx >= SGP_MARK_BITS) |=> !frame_sync_line;
	endproperty
	a_marker_off: assert property (p_marker_off) else $error("frame marker too long");

	property p_drive;
		s_present ##0 (pidx < SGP_DATA_BITS) |=> serial_out_oe;
	endproperty
	a_drive: assert property (p_drive) else $error("data bit not driven");

	property p_tri_low;
		s_present ##0 (pidx >= SGP_DATA_BITS) |=> !serial_out_line;
	endproperty
	a_tri_low: assert property (p_tri_low) else $error("multiplier bit not low");

	property p_tx_last;
		s_present ##0 (pidx == 8'h1F) |=> serial_out_line == $past(q.tx1[7]);
	endproperty
	a_tx_last: assert property (p_tx_last) else $error("outbound bit 32 wrong");

	property p_tx2_first;
		s_present ##0 (pidx == 8'h20) |=> serial_out_line == $past(q.tx2[24]);
	endproperty
	a_tx2_first: assert property (p_tx2_first) else $error("outbound bit 33 wrong");

	property p_tx2_last;
		s_present ##0 (pidx == 8'h3F) |=> serial_out_line == $past(q.tx2[7]);
	endproperty
	a_tx2_last: assert property (p_tx2_last) else $error("outbound bit 64 wrong");

	property p_rx_last;
		s_capture ##0 (q.idx == 8'h1F) |=> q.rx1[7] == $past(q.di_lv);
	endproperty
	a_rx_last: assert property (p_rx_last) else $error("inbound bit 32 misplaced");

	property p_rx2_first;
		s_capture ##0 (q.idx == 8'h20) |=> q.rx2[24] == $past(q.di_lv);
	endproperty
	a_rx2_first: assert property (p_rx2_first) else $error("inbound bit 33 misplaced");

	property p_rx2_last;
		s_capture ##0 (q.idx == 8'h3F) |=> q.rx2[7] == $past(q.di_lv);
	endproperty
	a_rx2_last: assert property (p_rx2_last) else $error("inbound bit 64 misplaced");

	property p_start;
		s_present ##0 (q.st == SGP_IDLE) |=> q.st == SGP_RUN && q.idx == 8'h00;
	endproperty
	a_start: assert property (p_start) else $error("stream did not start at bit 0");

	property p_advance;
		s_capture ##0 (!last_bit) |=> q.idx == $past(q.idx) + 8'h01;
	endproperty
	a_advance: assert property (p_advance) else $error("bit position skipped");

	property p_len_long;
		q.st == SGP_RUN |-> q.idx <= SGP_LAST_LONG;
	endproperty
	a_len_long: assert property (p_len_long) else $error("long stream overran");

	property p_sata_len;
		s_capture ##0 (q.sata && q.idx == SGP_LAST_SHORT) |=> q.st == SGP_RUN;
	endproperty
	a_sata_len: assert property (p_sata_len) else $error("long stream ended early");

	property p_quiet;
		clk_en && fall && !present |=> !frame_sync_line && !serial_out_line && !serial_out_oe;
	endproperty
	a_quiet: assert property (p_quiet) else $error("idle link not quiet");

	property p_stand;
		clk_en && !fall |=> $stable(frame_sync_line) && $stable(serial_out_line)
			&& $stable(serial_out_oe);
	endproperty
	a_stand: assert property (p_stand) else $error("link output changed between bits");

	property p_rx_hold;
		clk_en && q.st == SGP_IDLE && !present |=> $stable(q.rx1) && $stable(q.rx2);
	endproperty
	a_rx_hold: assert property (p_rx_hold) else $error("receive words changed while idle");

	property p_cnt_ro;
		clk_en && done && apb_req.pwrite && apb_req.paddr == SGP_RX_CFG
			&& !(rise && q.st == SGP_RUN && last_bit) |=> $stable(q.cnt);
	endproperty
	a_cnt_ro: assert property (p_cnt_ro) else $error("receive count written");

	property p_cnt_mirror;
		s_ask ##0 (!apb_req.pwrite && apb_req.paddr == SGP_RX_CFG)
			|=> apb_rsp.prdata[SGP_CNT_LSB +: 8] == $past(q.cnt);
	endproperty
	a_cnt_mirror: assert property (p_cnt_mirror) else $error("count not mirrored");

	property p_unmapped;
		s_ask ##0 (!mapped) |=> apb_rsp.pready && apb_rsp.pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

	property p_cnt_wr;
		clk_en && wr_cfg |=> q.cnt == $past(apb_req.pwdata[SGP_CNT_LSB +: 8]);
	endproperty
	a_cnt_wr: assert property (p_cnt_wr) else $error("count write lost");

	property p_pat_wr;
		clk_en && wr_cfg |=> q.pat == $past(apb_req.pwdata[SGP_PAT_LSB +: 4]);
	endproperty
	a_pat_wr: assert property (p_pat_wr) else $error("pattern write lost");

	property p_sata_wr;
		clk_en && done && apb_req.pwrite && !q.rsp.pslverr && apb_req.paddr == SGP_CTRL_ADDR
			|=> q.sata == $past(apb_req.pwdata[SGP_SATA_BIT]);
	endproperty
	a_sata_wr: assert property (p_sata_wr) else $error("length select write lost");

endmodule
`default_nettype wire

// >>> rtl/sgp_pkg.sv
// Package: register map, field layout, reset values and types of the general-purpose stream block
`default_nettype none
package sgp_pkg;
	// Register indexes within a group, and the group byte bases
	localparam logic [7:0] SGP_IDX_CFG   = 8'h00;
	localparam logic [7:0] SGP_IDX_W1    = 8'h01;
	localparam logic [7:0] SGP_IDX_W2    = 8'h02;
	localparam logic [7:0] SGP_TX_BASE   = 8'h00;
	localparam logic [7:0] SGP_RX_BASE   = 8'h10;
	localparam logic [7:0] SGP_CTRL_ADDR = 8'h20;
	// Byte addresses: base plus four times the index
	localparam logic [7:0] SGP_TX_CFG = SGP_TX_BASE + (SGP_IDX_CFG << 2);
	localparam logic [7:0] SGP_TX_W1  = SGP_TX_BASE + (SGP_IDX_W1 << 2);
	localparam logic [7:0] SGP_TX_W2  = SGP_TX_BASE + (SGP_IDX_W2 << 2);
	localparam logic [7:0] SGP_RX_CFG = SGP_RX_BASE + (SGP_IDX_CFG << 2);
	localparam logic [7:0] SGP_RX_W1  = SGP_RX_BASE + (SGP_IDX_W1 << 2);
	localparam logic [7:0] SGP_RX_W2  = SGP_RX_BASE + (SGP_IDX_W2 << 2);
	// Field positions
	localparam int SGP_CNT_LSB  = 16;
	localparam int SGP_PAT_LSB  = 24;
	localparam int SGP_SATA_BIT = 0;
	// Reset values
	localparam logic [7:0]  SGP_CNT_RST  = 8'h00;
	localparam logic [3:0]  SGP_PAT_RST  = 4'h0;
	localparam logic [31:0] SGP_WORD_RST = 32'h0000_0000;
	localparam logic        SGP_SATA_RST = 1'b0;
	// Stream constants
	localparam logic [7:0] SGP_CNT_INF    = 8'hFF;
	localparam logic [7:0] SGP_LAST_SHORT = 8'h0B;
	localparam logic [7:0] SGP_LAST_LONG  = 8'hBF;
	localparam logic [7:0] SGP_MARK_BITS  = 8'h04;
	localparam logic [7:0] SGP_DATA_BITS  = 8'h40;

	typedef enum logic [0:0] {
		SGP_IDLE = 1'b0,
		SGP_RUN  = 1'b1
	} sgp_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} sgp_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} sgp_apb_rsp_t;

	typedef struct packed {
		sgp_state_t   st;
		logic [7:0]   idx;
		logic [7:0]   cnt;
		logic [3:0]   pat;
		logic         sata;
		logic [31:0]  tx1;
		logic [31:0]  tx2;
		logic [31:0]  rx1;
		logic [31:0]  rx2;
		logic [2:0]   ck_sy;
		logic [2:0]   di_sy;
		logic         ck_lv;
		logic         di_lv;
		logic         fs;
		logic         dout;
		logic         doe;
		sgp_apb_rsp_t rsp;
	} sgp_regs_t;

	// Stream bit j of a word: byte 3 bit 0 first, byte 0 bit 7 last
	function automatic logic [4:0] sgp_pos(input logic [4:0] j);
		return {~j[4:3], j[2:0]};
	endfunction
endpackage
`default_nettype wire

// >>> tb/sgp_target_model.sv
// Backplane target model: makes the link clock, drives inbound bits, records outbound bits
`default_nettype none
module sgp_target_model (
	// Control from the bench
	input  wire logic         go,
	input  wire logic [9:0]   nbits,
	input  wire logic [511:0] in_bits,
	output logic              done,
	// Link
	output logic              serial_clock_line,
	output logic              serial_in_line,
	input  wire logic         frame_sync_line,
	input  wire logic         serial_out_line,
	input  wire logic         serial_out_oe,
	// Recorded bits
	output logic [511:0]      fs_bits,
	output logic [511:0]      out_bits,
	output logic [511:0]      oe_bits
);
	timeunit 1ns;
	timeprecision 100ps;
	// Clock stands high between frames; bit k shown at fall k, read before fall k+1
	initial begin
		done = 1'b0;
		serial_clock_line = 1'b1;
		serial_in_line = 1'b1;
		forever begin
			@(posedge go);
			done = 1'b0;
			for (int k = 0; k < nbits; k++) begin
				serial_clock_line = 1'b0;
				serial_in_line = in_bits[k];
				#62.5 serial_clock_line = 1'b1;
				#60 fs_bits[k] = frame_sync_line;
				out_bits[k] = serial_out_line;
				oe_bits[k] = serial_out_oe;
				#2.5;
			end
			serial_in_line = ~serial_in_line;
			done = 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Testbench for the general-purpose stream block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sgp_pkg::*;
	logic         pclk, presetn, clk_en, sclk, sin, fs, sout, soe, go, done;
	sgp_apb_req_t req;
	sgp_apb_rsp_t rsp;
	logic [9:0]   nbits;
	logic [511:0] inb, fsb, ob, oeb;
	int           seed, miscompares, comparisons;
	sgp_gp_stream DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(req),
		.apb_rsp(rsp), .serial_clock_line(sclk), .serial_in_line(sin),
		.frame_sync_line(fs), .serial_out_line(sout), .serial_out_oe(soe));
	sgp_target_model partner (.go(go), .nbits(nbits), .in_bits(inb), .done(done),
		.serial_clock_line(sclk), .serial_in_line(sin), .frame_sync_line(fs),
		.serial_out_line(sout), .serial_out_oe(soe), .fs_bits(fsb), .out_bits(ob),
		.oe_bits(oeb));
	always #5 pclk = ~pclk;
	function automatic int wpos(input int k);
		return (3 - (k % 32) / 8) * 8 + k % 8;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x, "read data");
		chk(e, xe, "read error");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chk(e, 1'b0, "write error");
	endtask
	task automatic run(input int n);
		nbits = n[9:0];
		go = 1'b1;
		#1 go = 1'b0;
		wait (done === 1'b1);
	endtask
	task automatic stream(input logic [7:0] cnt, input logic sata, input int n);
		int          len;
		logic        b;
		logic [3:0]  pat;
		logic [31:0] t1, t2, e1, e2;
		len = sata ? 192 : 12;
		pat = 4'($random(seed));
		t1 = $random(seed);
		t2 = $random(seed);
		for (int k = 0; k < 512; k++) inb[k] = 1'($random(seed));
		wr(SGP_TX_W1, t1);
		wr(SGP_TX_W2, t2);
		wr(SGP_CTRL_ADDR, {31'h0, sata});
		wr(SGP_TX_CFG, {4'hF, pat, cnt, 16'hFFFF});
		rd(SGP_TX_CFG, {4'h0, pat, cnt, 16'h0}, 1'b0);
		rd(SGP_RX_CFG, {8'h0, cnt, 16'h0}, 1'b0);
		run(n * len);
		for (int k = 0; k < n * len; k++) begin
			b = ((k % len) < 32) ? t1[wpos(k % len)] : t2[wpos(k % len)];
			chk(fsb[k], ((k % len) < 4) ? pat[k % len] : 1'b0, "sync");
			chk(oeb[k], (k % len) < 64, "enable");
			chk(ob[k], ((k % len) < 64) ? b : 1'b0, "out");
		end
		if (cnt == 8'hFF) begin
			rd(SGP_RX_CFG, {8'h0, 8'hFF, 16'h0}, 1'b0);
			wr(SGP_TX_CFG, {4'h0, pat, 8'h00, 16'h0});
		end
		run(1);
		chk({fsb[0], ob[0], oeb[0]}, 3'b000, "idle");
		e1 = '0;
		e2 = '0;
		for (int j = 0; j < len && j < 64; j++) begin
			if (j < 32) e1[wpos(j)] = inb[(n - 1) * len + j];
			else e2[wpos(j)] = inb[(n - 1) * len + j];
		end
		rd(SGP_RX_W1, e1, 1'b0);
		rd(SGP_RX_W2, e2, 1'b0);
		rd(SGP_TX_CFG, {4'h0, pat, 8'h00, 16'h0}, 1'b0);
	endtask
	task final_report;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		final_report;
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		clk_en = 1'b1;
		req = '0;
		go = 1'b0;
		nbits = '0;
		inb = '0;
		seed = 34275;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(SGP_TX_CFG, 32'h0, 1'b0);
		rd(SGP_TX_W2, 32'h0, 1'b0);
		rd(SGP_RX_CFG, 32'h0, 1'b0);
		rd(SGP_RX_W2, 32'h0, 1'b0);
		rd(8'h24, 32'h0, 1'b1);
		wr(SGP_RX_W1, 32'hFFFF_FFFF);
		rd(SGP_RX_W1, 32'h0, 1'b0);
		wr(SGP_TX_CFG, {8'h0, 8'h01, 16'h0});
		@(posedge pclk);
		clk_en <= 1'b0;
		repeat (2) @(posedge pclk);
		run(1);
		@(posedge pclk);
		clk_en <= 1'b1;
		chk({fsb[0], ob[0], oeb[0]}, 3'b000, "frozen link");
		rd(SGP_RX_CFG, {8'h0, 8'h01, 16'h0}, 1'b0);
		wr(SGP_TX_CFG, 32'h0);
		stream(8'h01, 1'b0, 1);
		stream(8'h02, 1'b1, 2);
		stream(8'hFF, 1'b0, 3);
		final_report;
	end
endmodule
`default_nettype wire
